// file: core/fesl_pkg.sv
package fesl_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the control port.
    // ------------------------------------------------------------------
    localparam logic [7:0] FESL_LINE1_FAULT_LATCHED_ADDR = 8'h38;
    localparam logic [7:0] FESL_LINE2_FAULT_LATCHED_ADDR = 8'h39;
    localparam logic [7:0] FESL_HEADSET_EVENT_LATCHED_ADDR = 8'h3a;
    localparam logic [7:0] FESL_THRESHOLD_VOICE_EVENT_LATCHED_ADDR = 8'h3b;
    localparam logic [7:0] FESL_CLOCK_EVENT_CURRENT_ADDR = 8'h3c;

    // ------------------------------------------------------------------
    // Widths and reset values.
    // ------------------------------------------------------------------
    localparam int unsigned FESL_DATA_W = 8;
    localparam logic [7:0] FESL_REG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int unsigned FESL_POS_SHORT_BIT = 7;      // Positive-leg short circuit.
    localparam int unsigned FESL_NEG_SHORT_BIT = 6;      // Negative-leg short circuit.
    localparam int unsigned FESL_POS_VGND_BIT = 5;       // Positive driver virtual ground.
    localparam int unsigned FESL_NEG_VGND_BIT = 4;       // Negative driver virtual ground.
    localparam int unsigned FESL_CONV1_MASK_BIT = 3;     // Converter one overload mask.
    localparam int unsigned FESL_CONV2_MASK_BIT = 2;     // Converter two overload mask.
    localparam int unsigned FESL_REG_MASK_BIT = 1;       // Regulator short mask.
    localparam int unsigned FESL_REG_SHORT_BIT = 0;      // Regulator short latched.
    localparam int unsigned FESL_HS_INSERT_BIT = 3;
    localparam int unsigned FESL_HS_REMOVE_BIT = 2;
    localparam int unsigned FESL_HS_BUTTON_BIT = 1;
    localparam int unsigned FESL_AIN_UPPER_BIT = 7;
    localparam int unsigned FESL_AIN_LOWER_BIT = 6;
    localparam int unsigned FESL_VOICE_UP_BIT = 5;
    localparam int unsigned FESL_VOICE_DOWN_BIT = 4;
    localparam int unsigned FESL_CLK_ERR_BIT = 7;
    localparam int unsigned FESL_PLL_LOCK_BIT = 6;

    // ------------------------------------------------------------------
    // Masks of implemented bits per register.
    // ------------------------------------------------------------------
    localparam logic [7:0] FESL_LINE1_FLAG_MASK = 8'hf0;
    localparam logic [7:0] FESL_LINE1_RW_MASK = 8'h0c;
    localparam logic [7:0] FESL_LINE2_FLAG_MASK = 8'hf1;
    localparam logic [7:0] FESL_LINE2_RW_MASK = 8'h02;
    localparam logic [7:0] FESL_HEADSET_FLAG_MASK = 8'h0e;
    localparam logic [7:0] FESL_THRESH_FLAG_MASK = 8'hf0;
    localparam logic [7:0] FESL_CLOCK_LIVE_MASK = 8'hc0;

endpackage : fesl_pkg

// file: core/fesl_flag_if.sv
`timescale 1ns/100ps
interface fesl_flag_if;
    logic [7:0] set;    // Per-bit event detected this cycle.
    logic [7:0] clr;    // Per-bit clear from a register read.
    logic [7:0] flags;  // Current sticky flag state.

    modport bank (
        input  set,
        input  clr,
        output flags
    );
    modport user (
        output set,
        output clr,
        input  flags
    );
endinterface : fesl_flag_if

// file: core/fesl_flag_bank.sv
`timescale 1ns/100ps
module fesl_flag_bank
    import fesl_pkg::*;
(
    input  wire logic clk,        // System clock.
    input  wire logic nrst,       // Asynchronous reset, active low.
    fesl_flag_if.bank fl          // Set, clear and flag state.
);

    logic [7:0] flags_reg;

    // ------------------------------------------------------------------
    // Sticky flags.
    // ------------------------------------------------------------------
    // A set in the same cycle as the clearing read wins, so no event is lost.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= FESL_REG_RESET;
        end else begin
            flags_reg <= (flags_reg & ~fl.clr) | fl.set;
        end
    end

    assign fl.flags = flags_reg;

endmodule // fesl_flag_bank

// file: core/fesl_top.sv
`timescale 1ns/100ps
// Behaviour
// - Line one leg shorts latch in bits 7,6.
// - Line one virtual ground faults latch bits 5,4.
// - Line one bits 3,2 mask converter overloads.
// - Line two leg shorts latch in bits 7,6.
// - Line two virtual ground faults latch bits 5,4.
// - Line two bit 1 masks regulator short.
// - Line two bit 0 latches regulator short.
// - Headset insert, remove, button latch bits 3-1.
// - Analog input threshold faults latch bits 7,6.
// - Voice activity up/down latch bits 5,4.
// - Clock error, PLL lock live in 7,6.
// - Reserved bits read zero; host writes zero.
// - All registers reset to zero.
module fesl_top
    import fesl_pkg::*;
(
    input  wire logic       clk,                   // System clock, 10 MHz.
    input  wire logic       nrst,                  // Asynchronous reset, active low.
    input  wire logic [7:0] reg_addr,              // Register offset from the control port.
    input  wire logic       reg_wr,                // Write strobe, one cycle.
    input  wire logic [7:0] reg_wdata,             // Write data.
    input  wire logic       reg_rd,                // Read strobe, one cycle.
    output logic      [7:0] reg_rdata,             // Read data, held until next read.
    input  wire logic       line1_pos_short,       // Line one positive pin short detected.
    input  wire logic       line1_neg_short,       // Line one negative pin short detected.
    input  wire logic       line1_pos_vgnd,        // Line one positive driver leg ground fault.
    input  wire logic       line1_neg_vgnd,        // Line one negative driver leg ground fault.
    input  wire logic       line2_pos_short,       // Line two positive pin short detected.
    input  wire logic       line2_neg_short,       // Line two negative pin short detected.
    input  wire logic       line2_pos_vgnd,        // Line two positive driver leg ground fault.
    input  wire logic       line2_neg_vgnd,        // Line two negative driver leg ground fault.
    input  wire logic       regulator_short,       // Analog regulator short detected.
    input  wire logic       headset_insert,        // Headset insertion detected.
    input  wire logic       headset_remove,        // Headset removal detected.
    input  wire logic       headset_button,        // Headset button detected.
    input  wire logic       ain_upper_fault,       // General analog input above upper threshold.
    input  wire logic       ain_lower_fault,       // General analog input below lower threshold.
    input  wire logic       voice_power_up,        // Voice activity power-up detection.
    input  wire logic       voice_power_down,      // Voice activity power-down detection.
    input  wire logic       clock_error,           // Clock error condition, live.
    input  wire logic       pll_lock,              // PLL lock condition, live.
    input  wire logic       conv1_overload,        // Converter one overload fault.
    input  wire logic       conv2_overload,        // Converter two overload fault.
    output logic            conv1_overload_mask,   // Converter one overload mask.
    output logic            conv2_overload_mask,   // Converter two overload mask.
    output logic            regulator_short_mask,  // Regulator short mask.
    output logic            fault_irq              // Interrupt indication, active high.
);

    // ------------------------------------------------------------------
    // Flag banks.
    // ------------------------------------------------------------------
    fesl_flag_if line1_if ();
    fesl_flag_if line2_if ();
    fesl_flag_if hs_if ();
    fesl_flag_if th_if ();

    fesl_flag_bank u_line1 (.clk(clk), .nrst(nrst), .fl(line1_if.bank));
    fesl_flag_bank u_line2 (.clk(clk), .nrst(nrst), .fl(line2_if.bank));
    fesl_flag_bank u_hs    (.clk(clk), .nrst(nrst), .fl(hs_if.bank));
    fesl_flag_bank u_th    (.clk(clk), .nrst(nrst), .fl(th_if.bank));

    logic [7:0] line1_set;
    logic [7:0] line2_set;
    logic [7:0] hs_set;
    logic [7:0] th_set;
    logic       rd_line1;
    logic       rd_line2;
    logic       rd_hs;
    logic       rd_th;
    logic [7:0] live_reg;
    logic       conv1_mask_reg;
    logic       conv2_mask_reg;
    logic       reg_mask_reg;
    logic [7:0] rdata_reg;
    logic       irq_reg;
    logic [7:0] rdata_next;
    logic       irq_next;

    // Returns a byte holding val at the given position, all other bits zero.
    function automatic logic [7:0] bit_at(input int unsigned pos, input logic val);
        logic [7:0] v;
        v = 8'h00;
        v[pos[2:0]] = val;
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Event routing into flag positions.
    // ------------------------------------------------------------------
    // Unimplemented positions never set, so reserved bits stay zero.
    always_comb begin
        line1_set = bit_at(FESL_POS_SHORT_BIT, line1_pos_short)
                  | bit_at(FESL_NEG_SHORT_BIT, line1_neg_short)
                  | bit_at(FESL_POS_VGND_BIT, line1_pos_vgnd)
                  | bit_at(FESL_NEG_VGND_BIT, line1_neg_vgnd);
        line2_set = bit_at(FESL_POS_SHORT_BIT, line2_pos_short)
                  | bit_at(FESL_NEG_SHORT_BIT, line2_neg_short)
                  | bit_at(FESL_POS_VGND_BIT, line2_pos_vgnd)
                  | bit_at(FESL_NEG_VGND_BIT, line2_neg_vgnd)
                  | bit_at(FESL_REG_SHORT_BIT, regulator_short);
        hs_set = bit_at(FESL_HS_INSERT_BIT, headset_insert)
               | bit_at(FESL_HS_REMOVE_BIT, headset_remove)
               | bit_at(FESL_HS_BUTTON_BIT, headset_button);
        th_set = bit_at(FESL_AIN_UPPER_BIT, ain_upper_fault)
               | bit_at(FESL_AIN_LOWER_BIT, ain_lower_fault)
               | bit_at(FESL_VOICE_UP_BIT, voice_power_up)
               | bit_at(FESL_VOICE_DOWN_BIT, voice_power_down);
    end

    assign line1_if.set = line1_set & FESL_LINE1_FLAG_MASK;
    assign line2_if.set = line2_set & FESL_LINE2_FLAG_MASK;
    assign hs_if.set = hs_set & FESL_HEADSET_FLAG_MASK;
    assign th_if.set = th_set & FESL_THRESH_FLAG_MASK;

    // ------------------------------------------------------------------
    // Read-clear decode.
    // ------------------------------------------------------------------
    // A read of a latched register clears its flags after the sample.
    assign rd_line1 = reg_rd && (reg_addr == FESL_LINE1_FAULT_LATCHED_ADDR);
    assign rd_line2 = reg_rd && (reg_addr == FESL_LINE2_FAULT_LATCHED_ADDR);
    assign rd_hs = reg_rd && (reg_addr == FESL_HEADSET_EVENT_LATCHED_ADDR);
    assign rd_th = reg_rd && (reg_addr == FESL_THRESHOLD_VOICE_EVENT_LATCHED_ADDR);
    assign line1_if.clr = {8{rd_line1}};
    assign line2_if.clr = {8{rd_line2}};
    assign hs_if.clr = {8{rd_hs}};
    assign th_if.clr = {8{rd_th}};

    // ------------------------------------------------------------------
    // Live clock conditions.
    // ------------------------------------------------------------------
    // Sampled every cycle, never held.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            live_reg <= FESL_REG_RESET;
        end else begin
            live_reg <= bit_at(FESL_CLK_ERR_BIT, clock_error)
                      | bit_at(FESL_PLL_LOCK_BIT, pll_lock);
        end
    end

    // ------------------------------------------------------------------
    // Mask bits, writable by the host.
    // ------------------------------------------------------------------
    // Writes to other bits and to read-only registers are ignored.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv1_mask_reg <= 1'b0;
            conv2_mask_reg <= 1'b0;
            reg_mask_reg <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == FESL_LINE1_FAULT_LATCHED_ADDR) begin
                conv1_mask_reg <= reg_wdata[FESL_CONV1_MASK_BIT];
                conv2_mask_reg <= reg_wdata[FESL_CONV2_MASK_BIT];
            end
            if (reg_addr == FESL_LINE2_FAULT_LATCHED_ADDR) begin
                reg_mask_reg <= reg_wdata[FESL_REG_MASK_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------
    // Unmapped offsets and reserved bits read as zero.
    always_comb begin
        case (reg_addr)
            FESL_LINE1_FAULT_LATCHED_ADDR: begin
                rdata_next = (line1_if.flags & FESL_LINE1_FLAG_MASK)
                           | bit_at(FESL_CONV1_MASK_BIT, conv1_mask_reg)
                           | bit_at(FESL_CONV2_MASK_BIT, conv2_mask_reg);
            end
            FESL_LINE2_FAULT_LATCHED_ADDR: begin
                rdata_next = (line2_if.flags & FESL_LINE2_FLAG_MASK)
                           | bit_at(FESL_REG_MASK_BIT, reg_mask_reg);
            end
            FESL_HEADSET_EVENT_LATCHED_ADDR: begin
                rdata_next = hs_if.flags & FESL_HEADSET_FLAG_MASK;
            end
            FESL_THRESHOLD_VOICE_EVENT_LATCHED_ADDR: begin
                rdata_next = th_if.flags & FESL_THRESH_FLAG_MASK;
            end
            FESL_CLOCK_EVENT_CURRENT_ADDR: begin
                rdata_next = live_reg & FESL_CLOCK_LIVE_MASK;
            end
            default: begin
                rdata_next = FESL_REG_RESET;
            end
        endcase
    end

    // Read data is captured on the read strobe and held until the next read.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= FESL_REG_RESET;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt indication.
    // ------------------------------------------------------------------
    // Any latched flag raises it, except a masked regulator short; an unmasked converter overload input raises it too.
    always_comb begin
        irq_next = (|(line1_if.flags & FESL_LINE1_FLAG_MASK))
                 | (|(line2_if.flags & FESL_LINE2_FLAG_MASK & ~bit_at(FESL_REG_SHORT_BIT, 1'b1)))
                 | (line2_if.flags[FESL_REG_SHORT_BIT] & ~reg_mask_reg)
                 | (|(hs_if.flags & FESL_HEADSET_FLAG_MASK))
                 | (|(th_if.flags & FESL_THRESH_FLAG_MASK))
                 | (conv1_overload & ~conv1_mask_reg)
                 | (conv2_overload & ~conv2_mask_reg);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign conv1_overload_mask = conv1_mask_reg;
    assign conv2_overload_mask = conv2_mask_reg;
    assign regulator_short_mask = reg_mask_reg;
    assign fault_irq = irq_reg;

endmodule // fesl_top

// file: testbench/fesl_top_assertions.sv
`timescale 1ns/100ps
module fesl_chk
    import fesl_pkg::*;
(
    input  wire logic       clk,                  // System clock.
    input  wire logic       nrst,                 // Reset, active low.
    input  wire logic [7:0] reg_addr,             // Offset.
    input  wire logic       reg_wr,               // Write strobe.
    input  wire logic [7:0] reg_wdata,            // Write data.
    input  wire logic       reg_rd,               // Read strobe.
    input  wire logic [7:0] reg_rdata,            // Read data.
    input  wire logic       line1_pos_short,      // Line one short.
    input  wire logic       regulator_short,      // Regulator short.
    input  wire logic       headset_insert,       // Headset insert.
    input  wire logic       ain_upper_fault,      // Upper threshold.
    input  wire logic       clock_error,          // Live clock error.
    input  wire logic       pll_lock,             // Live lock.
    input  wire logic       conv1_overload,       // Overload one.
    input  wire logic       conv1_overload_mask,  // Mask one.
    input  wire logic       conv2_overload_mask,  // Mask two.
    input  wire logic       regulator_short_mask, // Regulator mask.
    input  wire logic       fault_irq             // Interrupt.
);
    // ------------------------------------------------------------------
    // Checks on the register port.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Gives the bits that must read zero at an offset; unmapped offsets read all zero.
    function automatic logic [7:0] resv(input logic [7:0] a);
        case (a)
            FESL_LINE1_FAULT_LATCHED_ADDR: return ~(FESL_LINE1_FLAG_MASK | FESL_LINE1_RW_MASK);
            FESL_LINE2_FAULT_LATCHED_ADDR: return ~(FESL_LINE2_FLAG_MASK | FESL_LINE2_RW_MASK);
            FESL_HEADSET_EVENT_LATCHED_ADDR: return ~FESL_HEADSET_FLAG_MASK;
            FESL_THRESHOLD_VOICE_EVENT_LATCHED_ADDR: return ~FESL_THRESH_FLAG_MASK;
            FESL_CLOCK_EVENT_CURRENT_ADDR: return ~FESL_CLOCK_LIVE_MASK;
            default: return 8'hff;
        endcase
    endfunction

    // A flag seen at its source is returned by a read two cycles later.
    property latch_p(logic src, logic [7:0] a, int b);
        src ##1 !(reg_rd && reg_addr == a) ##1 (reg_rd && reg_addr == a) |=> reg_rdata[b];
    endproperty

    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    resv_zero_a: assert property (reg_rd |=> (reg_rdata & resv($past(reg_addr))) == 8'h00)
        else $error("reserved read bit set");
    conv_mask_a: assert property (reg_wr && reg_addr == FESL_LINE1_FAULT_LATCHED_ADDR |=>
        conv1_overload_mask == $past(reg_wdata[3]) && conv2_overload_mask == $past(reg_wdata[2]))
        else $error("converter masks not written");
    reg_mask_a: assert property (reg_wr && reg_addr == FESL_LINE2_FAULT_LATCHED_ADDR |=>
        regulator_short_mask == $past(reg_wdata[1])) else $error("regulator mask not written");
    mask_hold_a: assert property (!(reg_wr && reg_addr == FESL_LINE2_FAULT_LATCHED_ADDR) |=>
        $stable(regulator_short_mask)) else $error("regulator mask changed without a write");
    live_read_a: assert property (reg_rd && reg_addr == FESL_CLOCK_EVENT_CURRENT_ADDR |=>
        reg_rdata[7:6] == {$past(clock_error, 2), $past(pll_lock, 2)}) else $error("live bits wrong");
    line_latch_a: assert property (latch_p(line1_pos_short, FESL_LINE1_FAULT_LATCHED_ADDR, 7))
        else $error("line one short not latched");
    regshort_latch_a: assert property (latch_p(regulator_short, FESL_LINE2_FAULT_LATCHED_ADDR, 0))
        else $error("regulator short not latched");
    headset_latch_a: assert property (latch_p(headset_insert, FESL_HEADSET_EVENT_LATCHED_ADDR, 3))
        else $error("headset insert not latched");
    ain_latch_a: assert property (latch_p(ain_upper_fault, FESL_THRESHOLD_VOICE_EVENT_LATCHED_ADDR, 7))
        else $error("upper threshold not latched");
    overload_irq_a: assert property (conv1_overload && !conv1_overload_mask |=> fault_irq)
        else $error("unmasked overload gave no interrupt");

    live_read_c: cover property (reg_rd && reg_addr == FESL_CLOCK_EVENT_CURRENT_ADDR);
    irq_c: cover property ($rose(fault_irq));
    mask_write_c: cover property (reg_wr && reg_addr == FESL_LINE1_FAULT_LATCHED_ADDR);
endmodule // fesl_chk

bind fesl_top fesl_chk u_chk (.*);

// file: testbench/fesl_host_model.sv
`timescale 1ns/100ps
module fesl_host_model
    import fesl_pkg::*;
(
    input  wire logic       clk,       // System clock.
    output logic      [7:0] reg_addr,  // Register offset.
    output logic            reg_wr,    // Write strobe.
    output logic      [7:0] reg_wdata, // Write data.
    output logic            reg_rd     // Read strobe.
);
    // Starts with the port idle.
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // Writes one byte; bits outside the masks are sent as zero, then the lines are scrambled.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d & ((a == FESL_LINE1_FAULT_LATCHED_ADDR) ? FESL_LINE1_RW_MASK : FESL_LINE2_RW_MASK);
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // Reads one byte; the data is taken by the bench at the strobe's edge.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule // fesl_host_model

// file: testbench/fesl_top_tb.sv
`timescale 1ns/100ps
module fesl_top_tb
    import fesl_pkg::*;
;
    logic       clk, nrst, reg_wr, reg_rd, clk_err, pll, ov1, ov2, m1, m2, mr, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [7:0] src [4];
    logic [7:0] mk [4];
    logic [7:0] ad [4] = '{8'h38, 8'h39, 8'h3a, 8'h3b};
    logic [7:0] fm [4] = '{FESL_LINE1_FLAG_MASK, FESL_LINE2_FLAG_MASK, FESL_HEADSET_FLAG_MASK, FESL_THRESH_FLAG_MASK};
    logic [7:0] exp_q [$];
    logic [31:0] rnd;
    int         n_fail, samples_checked;

    fesl_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    fesl_top dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line1_pos_short(src[0][7]), .line1_neg_short(src[0][6]),
        .line1_pos_vgnd(src[0][5]), .line1_neg_vgnd(src[0][4]), .line2_pos_short(src[1][7]),
        .line2_neg_short(src[1][6]), .line2_pos_vgnd(src[1][5]), .line2_neg_vgnd(src[1][4]),
        .regulator_short(src[1][0]), .headset_insert(src[2][3]), .headset_remove(src[2][2]),
        .headset_button(src[2][1]), .ain_upper_fault(src[3][7]), .ain_lower_fault(src[3][6]),
        .voice_power_up(src[3][5]), .voice_power_down(src[3][4]), .clock_error(clk_err), .pll_lock(pll),
        .conv1_overload(ov1), .conv2_overload(ov2), .conv1_overload_mask(m1), .conv2_overload_mask(m2),
        .regulator_short_mask(mr), .fault_irq(irq));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // Notes the expected read data, then reads.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    // Raises a source pattern for one cycle.
    task automatic pulse(input int i, input logic [7:0] d);
        @(posedge clk);
        src[i] <= d;
        @(posedge clk);
        src[i] <= 8'h00;
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(negedge clk);
        check({7'h00, irq}, {7'h00, e});
        // Returns on a rising edge so that the next stimulus lands there.
        @(posedge clk);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Takes the oldest note whenever a read returns data.
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            #1;
            check(reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        #(5000 * 100);
        n_fail++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        {clk_err, pll, ov1, ov2} = 4'h0;
        src = '{8'h00, 8'h00, 8'h00, 8'h00};
        mk = '{8'h00, 8'h00, 8'h00, 8'h00};
        rnd = 32'h0000005d;
        nrst = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 8'h38; a < 8'h3e; a++) rd_chk(8'(a), FESL_REG_RESET);
        $display("reset test done");
        host.wr(FESL_LINE1_FAULT_LATCHED_ADDR, 8'h0c);
        host.wr(FESL_LINE2_FAULT_LATCHED_ADDR, 8'h02);
        host.wr(FESL_HEADSET_EVENT_LATCHED_ADDR, 8'hff);
        mk = '{8'h0c, 8'h02, 8'h00, 8'h00};
        @(negedge clk);
        check({5'h00, m1, m2, mr}, 8'h07);
        for (int i = 0; i < 3; i++) rd_chk(ad[i], mk[i]);
        $display("mask test done");
        for (int k = 0; k < 16; k++) begin
            rnd = xs(rnd);
            v = (k < 4) ? fm[k % 4] : (rnd[7:0] & fm[k % 4]);
            pulse(k % 4, v);
            rd_chk(ad[k % 4], v | mk[k % 4]);
            rd_chk(ad[k % 4], mk[k % 4]);
        end
        // An event in the cycle of the clearing read must survive that read.
        fork
            rd_chk(FESL_HEADSET_EVENT_LATCHED_ADDR, 8'h00);
            pulse(2, 8'h08);
        join
        rd_chk(FESL_HEADSET_EVENT_LATCHED_ADDR, 8'h08);
        $display("flag test done");
        pulse(1, 8'h01);
        irq_chk(1'b0);
        rd_chk(FESL_LINE2_FAULT_LATCHED_ADDR, 8'h03);
        host.wr(FESL_LINE2_FAULT_LATCHED_ADDR, 8'h00);
        pulse(1, 8'h01);
        irq_chk(1'b1);
        rd_chk(FESL_LINE2_FAULT_LATCHED_ADDR, 8'h01);
        irq_chk(1'b0);
        {ov1, ov2} <= 2'b11;
        irq_chk(1'b0);
        host.wr(FESL_LINE1_FAULT_LATCHED_ADDR, 8'h04);
        irq_chk(1'b1);
        ov1 <= 1'b0;
        irq_chk(1'b0);
        host.wr(FESL_LINE1_FAULT_LATCHED_ADDR, 8'h00);
        irq_chk(1'b1);
        ov2 <= 1'b0;
        irq_chk(1'b0);
        $display("interrupt test done");
        for (int j = 0; j < 5; j++) begin
            {clk_err, pll} <= 2'(j);
            rd_chk(FESL_CLOCK_EVENT_CURRENT_ADDR, {2'(j), 6'h00});
            rd_chk(FESL_CLOCK_EVENT_CURRENT_ADDR, {2'(j), 6'h00});
        end
        $display("live test done");
        host.wr(FESL_LINE1_FAULT_LATCHED_ADDR, 8'h0c);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(FESL_LINE1_FAULT_LATCHED_ADDR, FESL_REG_RESET);
        @(negedge clk);
        $display("second reset test done");
        conclude();
    end
endmodule // fesl_top_tb
